//--- pkg/sac_pkg.sv
// constants and types shared by the converter control and readout logic
package sac_pkg;
   localparam int CLK_HZ          = 50_000_000;  // system clock rate
   localparam int RESULT_W        = 16;          // result width in bits
   localparam int FIFO_DEPTH      = 8;           // results buffered
   localparam int CONV_TIME_NS    = 2500;        // longest conversion
   localparam int ACQ_START_NS    = 750;         // acquire after start
   localparam int POR_WAIT_US     = 20;          // host wait after reset
   localparam int WAKE_LOW_NS     = 200;         // wake_low_time
   localparam int NS_PER_S        = 1_000_000_000;
   // longest time rounds down, least time rounds up
   localparam int CONV_CYC  = (CONV_TIME_NS * (CLK_HZ / 1_000_000)) / 1000;
   localparam int ACQ_CYC   = (ACQ_START_NS * (CLK_HZ / 1_000_000) + 999)
                              / 1000;
   localparam int POR_CYC   = POR_WAIT_US * (CLK_HZ / 1_000_000);
   localparam int WAKE_CYC  = (WAKE_LOW_NS * (CLK_HZ / 1_000_000) + 999)
                              / 1000;
   localparam int BIT_CNT_W = 5;                 // counts 0..16
   localparam logic [15:0] SIM_SEED = 16'hACE1;  // stand-in code seed
   // conversion states
   typedef enum logic [3:0] {
      SAC_IDLE = 4'b0001,
      SAC_CONV = 4'b0010,
      SAC_DOWN = 4'b0100,
      SAC_WAKE = 4'b1000
   } sac_state_t;
endpackage

//--- pkg/sac_fifo_if.sv
// valid/ready carrier between converter core and result buffer
`timescale 1ns/1ps
interface sac_fifo_if #(parameter int W = 16);
   logic         valid;   // word offered
   logic         ready;   // word accepted
   logic [W-1:0] data;    // word itself
   modport src  (output valid, output data, input ready);
   modport sink (input valid, input data, output ready);
endinterface

//--- rtl/sac_fifo.sv
// small synchronous fifo holding finished conversion results
`timescale 1ns/1ps
module sac_fifo #(
   parameter int W     = 16,
   parameter int DEPTH = 8
) (
   input  wire logic   clk,
   input  wire logic   arst_n,
   sac_fifo_if.sink    wr,
   sac_fifo_if.src     rd
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0]  mem [DEPTH];        // storage words
   logic [AW:0]   wp_ff;              // write pointer with wrap bit
   logic [AW:0]   rp_ff;              // read pointer with wrap bit
   logic          full;
   logic          empty;
   logic          do_wr;
   logic          do_rd;

   // full when pointers differ only in wrap bit
   assign full     = (wp_ff[AW] != rp_ff[AW]) &&
                     (wp_ff[AW-1:0] == rp_ff[AW-1:0]);
   assign empty    = (wp_ff == rp_ff);
   assign wr.ready = !full;
   assign rd.valid = !empty;
   assign rd.data  = mem[rp_ff[AW-1:0]];
   assign do_wr    = wr.valid && !full;
   assign do_rd    = rd.ready && !empty;

   // storage is written without reset, pointers guard it
   always_ff @(posedge clk) begin
      if (do_wr) begin
         mem[wp_ff[AW-1:0]] <= wr.data;
      end
   end

   // pointer advance
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wp_ff <= '0;
         rp_ff <= '0;
      end else begin
         if (do_wr) begin
            wp_ff <= wp_ff + 1'b1;
         end
         if (do_rd) begin
            rp_ff <= rp_ff + 1'b1;
         end
      end
   end
endmodule

//--- rtl/sac_core.sv
// conversion control and serial readout of a 16-bit sar converter
`timescale 1ns/1ps
module sac_core
   import sac_pkg::*;
#(
   parameter int          CONV_CYCLES = sac_pkg::CONV_CYC,
   parameter int          POR_CYCLES  = sac_pkg::POR_CYC,
   parameter logic [15:0] CODE_SEED   = sac_pkg::SIM_SEED
) (
   input  wire logic                     clk,
   input  wire logic                     arst_n,
   input  wire logic                     convert_start,
   input  wire logic                     read_select_serial_in,
   input  wire logic                     sck,
   input  wire logic                     chain_mode,
   input  wire logic [sac_pkg::RESULT_W-1:0] sample_code,
   output logic                          busy,
   output logic                          sdo_o,
   output logic                          sdo_oe_n,
   output logic                          acquiring,
   output logic                          powered_down,
   output logic                          por_ready,
   output logic                          result_valid,
   output logic [sac_pkg::RESULT_W-1:0] result_word
);
   import sac_pkg::*;

   // one width serves both timers, sized for the longer count
   localparam int CW = $clog2(((CONV_CYCLES > POR_CYCLES) ?
                               CONV_CYCLES : POR_CYCLES) + 1);

   // pin synchronisers, first stage read only by second
   logic [1:0]          cnv_sync_ff;      // convert_start sync
   logic [1:0]          rsi_sync_ff;      // select or serial in sync
   logic [1:0]          sck_sync_ff;      // shift clock sync
   logic [1:0]          chn_sync_ff;      // chain strap sync
   logic                cnv_q_ff;         // previous start level
   logic                rsi_q_ff;         // previous select level
   logic                sck_q_ff;         // previous sck level
   logic                cnv_rise;
   logic                rsi_fall;
   logic                sck_rise;
   logic                cnv_s;
   logic                rsi_s;
   logic                chain_s;

   sac_state_t          state_ff;         // conversion state
   sac_state_t          nxt_state;
   logic [CW-1:0]       tmr_ff;           // conversion / wake timer
   logic [CW-1:0]       por_ff;           // post reset settle counter
   logic [RESULT_W-1:0] shreg_ff;         // output shift register
   logic [RESULT_W-1:0] code_ff;          // captured sample code
   logic [RESULT_W-1:0] seed_ff;          // sim lfsr, stepped but drives nothing
   logic                conv_done;
   logic                sdo_en;

   sac_fifo_if #(.W(RESULT_W)) wr_if ();
   sac_fifo_if #(.W(RESULT_W)) rd_if ();

   // two-stage synchronisers for every pin input
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnv_sync_ff <= 2'h0;
         rsi_sync_ff <= 2'h3;
         sck_sync_ff <= 2'h0;
         chn_sync_ff <= 2'h0;
      end else begin
         cnv_sync_ff <= {cnv_sync_ff[0], convert_start};
         rsi_sync_ff <= {rsi_sync_ff[0], read_select_serial_in};
         sck_sync_ff <= {sck_sync_ff[0], sck};
         chn_sync_ff <= {chn_sync_ff[0], chain_mode};
      end
   end

   assign cnv_s   = cnv_sync_ff[1];
   assign rsi_s   = rsi_sync_ff[1];
   assign chain_s = chn_sync_ff[1];

   // edge detectors work on the settled copies only
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnv_q_ff <= 1'b0;
         rsi_q_ff <= 1'b1;
         sck_q_ff <= 1'b0;
      end else begin
         cnv_q_ff <= cnv_s;
         rsi_q_ff <= rsi_s;
         sck_q_ff <= sck_sync_ff[1];
      end
   end

   assign cnv_rise = cnv_s && !cnv_q_ff;
   assign rsi_fall = !rsi_s && rsi_q_ff;
   assign sck_rise = sck_sync_ff[1] && !sck_q_ff;

   // arst_n stands for the supply monitor; logic restarts clean
   // settle counter tells the host when starts become valid
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         por_ff    <= '0;
         por_ready <= 1'b0;
      end else if (por_ff != CW'(POR_CYCLES)) begin
         por_ff    <= por_ff + 1'b1;
      end else begin
         por_ready <= 1'b1;
      end
   end

   assign conv_done = (state_ff == SAC_CONV) &&
                      (tmr_ff == CW'(CONV_CYCLES - 1));

   // next state; start edges inside a conversion are dropped
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         SAC_IDLE: begin
            if (cnv_rise) begin
               nxt_state = SAC_CONV;
            end
         end
         SAC_CONV: begin
            if (conv_done) begin
               nxt_state = cnv_s ? SAC_DOWN : SAC_IDLE;
            end
         end
         SAC_DOWN: begin
            // waking needs start low long enough
            if (!cnv_s) begin
               nxt_state = SAC_WAKE;
            end
         end
         SAC_WAKE: begin
            if (cnv_s) begin
               // short low pulse: wake not complete, stay down
               // timer lags the pin by one count, so compare one less
               nxt_state = (tmr_ff >= CW'(WAKE_CYC - 1)) ?
                           SAC_CONV : SAC_DOWN;
            end
         end
      endcase
   end

   // state register
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_ff <= SAC_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // timer: conversion length from internal clock, or wake low time
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         tmr_ff <= '0;
      end else if (nxt_state != state_ff) begin
         tmr_ff <= '0;
      end else if (state_ff == SAC_CONV || state_ff == SAC_WAKE) begin
         if (tmr_ff != '1) begin
            tmr_ff <= tmr_ff + 1'b1;
         end
      end
   end

   // status outputs, all registered
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         busy         <= 1'b0;
         acquiring    <= 1'b1;
         powered_down <= 1'b0;
      end else begin
         busy         <= (nxt_state == SAC_CONV);
         // track phase resumes fixed time after start
         acquiring    <= !(nxt_state == SAC_CONV &&
                           (state_ff != SAC_CONV ||
                            tmr_ff < CW'(ACQ_CYC - 1)));
         powered_down <= (nxt_state == SAC_DOWN);
      end
   end

   // stand-in for the analog result: input code captured as is, lfsr not mixed in
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         seed_ff <= 16'h0000;
         code_ff <= 16'h0000;
      end else begin
         if (seed_ff == 16'h0000) begin
            seed_ff <= CODE_SEED;
         end else if (conv_done) begin
            seed_ff <= {seed_ff[14:0],
                        seed_ff[15] ^ seed_ff[13] ^
                        seed_ff[12] ^ seed_ff[10]};
         end
         if (state_ff == SAC_CONV && tmr_ff == CW'(ACQ_CYC - 1)) begin
            code_ff <= sample_code;
         end
      end
   end

   // driver enable: chain always on, normal follows select
   assign sdo_en = chain_s || !rsi_s;

   // shift register: load at conversion end, shift on sck rise
   // in normal mode shifting is gated by the enable; the slow
   // sync means sck must stay under about 12 MHz here
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         shreg_ff <= 16'h0000;
      end else if (conv_done) begin
         shreg_ff <= code_ff;
      end else if (state_ff == SAC_CONV) begin
         shreg_ff <= shreg_ff;
      end else if (sck_rise && sdo_en) begin
         // chain pulls in upstream bit, normal fills zero
         shreg_ff <= {shreg_ff[RESULT_W-2:0],
                      chain_s & rsi_s};
      end
   end

   // pin outputs from flops; top bit held until first sck rise
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sdo_o    <= 1'b0;
         sdo_oe_n <= 1'b1;
      end else begin
         sdo_o    <= (conv_done) ? code_ff[RESULT_W-1]
                   : (sck_rise && sdo_en && state_ff != SAC_CONV)
                     ? shreg_ff[RESULT_W-2]
                     : shreg_ff[RESULT_W-1];
         sdo_oe_n <= !sdo_en;
      end
   end

   // results also queued for on-chip readers
   assign wr_if.valid = conv_done;
   assign wr_if.data  = code_ff;
   assign rd_if.ready = !result_valid;

   sac_fifo #(
      .W     (RESULT_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk    (clk),
      .arst_n (arst_n),
      .wr     (wr_if),
      .rd     (rd_if)
   );

   // one-word output holding stage, drained when shown
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         result_valid <= 1'b0;
         result_word  <= 16'h0000;
      end else if (rd_if.valid && !result_valid) begin
         result_valid <= 1'b1;
         result_word  <= rd_if.data;
      end else begin
         result_valid <= 1'b0;
      end
   end
endmodule

//--- tb/sac_core_checker.sv
// concurrent checks on the converter control block ports
`timescale 1ns/1ps
module sac_core_checker
   import sac_pkg::*;
#(
   parameter int CONV_CYCLES = 125,
   parameter int POR_CYCLES  = 1000
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic convert_start,
   input wire logic read_select_serial_in,
   input wire logic sck,
   input wire logic chain_mode,
   input wire logic busy,
   input wire logic sdo_o,
   input wire logic sdo_oe_n,
   input wire logic acquiring,
   input wire logic powered_down,
   input wire logic por_ready
);
   logic [9:0]  bcnt_ff; // cycles busy has been high
   logic [10:0] rcnt_ff; // cycles since reset release
   logic [3:0]  scnt_ff; // cycles since sck rise
   logic        sck_ff;  // sck one cycle ago
   logic [3:0]  lcnt_ff; // cycles start pin has been low
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   // busy age, cleared while busy is low
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) bcnt_ff <= 10'h000;
      else bcnt_ff <= busy ? bcnt_ff + 10'h001 : 10'h000;
   end
   // reset age, stops at the top so it never wraps
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) rcnt_ff <= 11'h000;
      else if (rcnt_ff != 11'h7FF) rcnt_ff <= rcnt_ff + 11'h001;
   end
   // sck edge age; raw pin sampled, so a few cycles of slack
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sck_ff  <= 1'b0;
         scnt_ff <= 4'hF;
      end else begin
         sck_ff <= sck;
         if (sck && !sck_ff) scnt_ff <= 4'h0;
         else if (scnt_ff != 4'hF) scnt_ff <= scnt_ff + 4'h1;
      end
   end
   // start low age, saturating; too short a low must not wake
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) lcnt_ff <= 4'h0;
      else if (convert_start) lcnt_ff <= 4'h0;
      else if (lcnt_ff != 4'hF) lcnt_ff <= lcnt_ff + 4'h1;
   end
   AST_BUSY_LEN: assert property (
      $fell(busy) |-> bcnt_ff == CONV_CYCLES)
      else $error("busy length wrong");
   AST_START: assert property (
      $rose(convert_start) && !busy && !powered_down && por_ready &&
      lcnt_ff >= 4'(WAKE_CYC)
      |-> ##[2:5] busy)
      else $error("start edge lost");
   AST_POR_GATE: assert property (
      !por_ready |-> !busy)
      else $error("conversion before ready");
   AST_POR_TIME: assert property (
      $rose(por_ready) |-> rcnt_ff inside {[POR_CYCLES-2:POR_CYCLES+2]})
      else $error("ready time wrong");
   AST_ACQ: assert property (
      $rose(acquiring) && busy |-> bcnt_ff inside {[ACQ_CYC-2:ACQ_CYC+1]})
      else $error("acquire time wrong");
   AST_PDOWN: assert property (
      $fell(busy) && convert_start |-> ##[0:3] powered_down)
      else $error("no power down");
   AST_PD_IDLE: assert property (
      powered_down |-> !busy)
      else $error("down while busy");
   AST_OE_OFF: assert property (
      (!chain_mode && read_select_serial_in) [*4] |-> sdo_oe_n)
      else $error("sdo driven unselected");
   AST_OE_ON: assert property (
      (!chain_mode && !read_select_serial_in) [*4] |-> !sdo_oe_n)
      else $error("sdo not driven");
   AST_OE_CHAIN: assert property (
      chain_mode [*4] |-> !sdo_oe_n)
      else $error("chain sdo off");
   AST_SHIFT: assert property (
      $changed(sdo_o) && !busy && !$fell(busy) |-> scnt_ff < 4'h8)
      else $error("sdo moved without sck");
endmodule
bind sac_core sac_core_checker #(
   .CONV_CYCLES(CONV_CYCLES),
   .POR_CYCLES(POR_CYCLES)
) chk (.clk, .arst_n, .convert_start, .read_select_serial_in, .sck,
   .chain_mode, .busy, .sdo_o, .sdo_oe_n, .acquiring, .powered_down,
   .por_ready);

//--- tb/sac_host_model.sv
// host model: conversion start, select or serial data, shift clock
`timescale 1ns/1ps
module sac_host_model (
   input  wire logic clk,
   input  wire logic busy,
   input  wire logic sdo_o,
   output logic      convert_start,
   output logic      read_select_serial_in,
   output logic      sck
);
   // idle: deselected, sck still outside frames
   initial begin
      convert_start = 1'b0;
      read_select_serial_in = 1'b1;
      sck = 1'b0;
   end
   // one conversion; poke adds a late start edge to be ignored
   task automatic convert(input bit hold, input bit poke);
      int n;
      convert_start <= 1'b0;
      repeat (16) @(posedge clk); // low past wake time
      convert_start <= 1'b1;
      @(posedge clk);
      if (!hold) convert_start <= 1'b0; // within 40ns
      for (n = 0; n < 10 && busy !== 1'b1; n++) @(posedge clk);
      if (poke) begin
         repeat (20) @(posedge clk);
         convert_start <= 1'b1;
      end
      for (n = 0; n < 300 && busy !== 1'b0; n++) @(posedge clk);
   endtask
   // low pulse too short to wake the part
   task automatic short_wake();
      convert_start <= 1'b0;
      repeat (3) @(posedge clk);
      convert_start <= 1'b1;
   endtask
   // frame of nb sck periods of 8 clk; sdo taken before each rise
   // sck kept below the 15MHz target, the pin sync limits it
   task automatic read(input int nb, input logic [15:0] sdi,
                       output logic [31:0] w);
      logic [31:0] s;
      s = {sdi, 16'h0000};
      w = 32'h0000_0000;
      read_select_serial_in <= s[31];
      repeat (4) @(posedge clk); // sck low round select fall
      for (int i = 0; i < nb; i++) begin
         w = {w[30:0], sdo_o};
         sck <= 1'b1;
         repeat (4) @(posedge clk);
         sck <= 1'b0;
         s = s << 1;
         read_select_serial_in <= s[31]; // next bit while sck low
         repeat (4) @(posedge clk);
      end
      read_select_serial_in <= 1'b1; // release
   endtask
endmodule

//--- tb/sac_core_bench.sv
// self-checking bench for the converter control and readout block
`timescale 1ns/1ps
module sac_core_bench;
   import sac_pkg::*;
   logic                clk, arst_n, chain_mode;
   logic [RESULT_W-1:0] sample_code, result_word, code, up;
   logic                convert_start, read_select_serial_in, sck;
   logic                busy, sdo_o, sdo_oe_n, acquiring;
   logic                powered_down, por_ready, result_valid;
   logic [15:0]         expq[$]; // results the fifo owes us
   logic [31:0]         w;       // word read serially
   int                  errors = 0, checks_done = 0, seed = 75247;
   // 50MHz clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // short power-on wait keeps the run brief
   sac_core #(.POR_CYCLES(20)) uut (.clk, .arst_n, .convert_start,
      .read_select_serial_in, .sck, .chain_mode, .sample_code, .busy,
      .sdo_o, .sdo_oe_n, .acquiring, .powered_down, .por_ready,
      .result_valid, .result_word);
   sac_host_model host (.clk, .busy, .sdo_o, .convert_start,
      .read_select_serial_in, .sck);
   task automatic chk1(input string nm, input logic e, input logic g);
      checks_done++;
      if (g !== e) begin
         errors++;
         $display("Error %s exp %b got %b", nm, e, g);
      end
   endtask
   task automatic chk16(input string nm, input logic [15:0] e,
                        input logic [15:0] g);
      checks_done++;
      if (g !== e) begin
         errors++;
         $display("Error %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // fresh random code, result noted for the fifo watcher
   task automatic conv(input bit hold, input bit poke);
      @(posedge clk);
      code = 16'($random(seed));
      sample_code <= code;
      expq.push_back(code);
      host.convert(hold, poke);
   endtask
   // watcher: oldest note against each buffered result
   always @(posedge clk) begin
      if (result_valid === 1'b1) begin
         if (expq.size() == 0) chk1("spare result", 1'b0, 1'b1);
         else chk16("result_word", expq.pop_front(), result_word);
      end
   end
   // hang guard, far beyond the expected few thousand cycles
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      $display("Error watchdog exp end got hang");
      give_verdict();
   end
   initial begin
      arst_n = 1'b0;
      chain_mode = 1'b0;
      sample_code = 16'h0000;
      repeat (3) @(posedge clk);
      chk1("sdo_oe_n", 1'b1, sdo_oe_n);
      arst_n <= 1'b1;
      for (int n = 0; n < 100 && por_ready !== 1'b1; n++) @(posedge clk);
      chk1("por_ready", 1'b1, por_ready);
      $display("test reset done");
      // normal mode: plain, held high, late restart edge
      for (int i = 0; i < 4; i++) begin
         conv(i[0], i == 2);
         repeat (4) @(posedge clk);
         chk1("powered_down", i[0] || i == 2, powered_down);
         host.read(16, 16'h0000, w);
         chk16("sdo word", code, w[15:0]);
         repeat (4) @(posedge clk);
         chk1("sdo_oe_n idle", 1'b1, sdo_oe_n);
      end
      $display("test normal done");
      // too short a low pulse leaves the part asleep
      conv(1'b1, 1'b0);
      host.short_wake();
      repeat (12) @(posedge clk);
      chk1("busy", 1'b0, busy);
      chk1("powered_down", 1'b1, powered_down);
      $display("test wake done");
      // chain: own word first, upstream word after 16 clocks
      chain_mode <= 1'b1;
      up = 16'($random(seed));
      conv(1'b0, 1'b0);
      chk1("chain sdo_oe_n", 1'b0, sdo_oe_n);
      host.read(32, up, w);
      chk16("chain own", code, w[31:16]);
      chk16("chain upstream", up, w[15:0]);
      $display("test chain done");
      repeat (20) @(posedge clk);
      chk1("queue empty", 1'b1, expq.size() == 0);
      give_verdict();
   end
endmodule
